// ### verilog/crypto_descriptor_assoc_decode.sv
/*
 * Decoder of the descriptor length and offset words and loader of the security
 * association: fetches the association through the descriptor's pointer, holds
 * control, keys and IVs, and hands the decoded settings and key words to the engines.
 * Assumes the descriptor DMA and the memory read port run on ref_clk_in.
 */
// Behaviour
// - For hash and HMAC the length word is the full message size in bytes.
// - Under GCM the length word is the count of bytes to be ciphered.
// - The offset word is where encryption starts in combined passes.
// - Under GCM the offset word counts the AAD bytes before ciphered data.
// - Every setting comes from the chain's association, never from fixed defaults.
// - The association chooses parallel engines; both then run together.
// - Algorithm, key size, keys and IVs are loaded from the association.
// - Fetch enable set fetches the association; clear reuses the held one, or fetches if none is held.
// - Keys and IVs are read from the descriptor's association pointer.
`default_nettype none
`include "crypto_descriptor_assoc_decode_regs.svh"

module crypto_descriptor_assoc_decode (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Descriptor from the chain DMA
	input wire logic desc_valid_in,
	output logic desc_ready_out,
	input wire assoc_decode_pkg::word_type descriptor_length_word_in,
	input wire assoc_decode_pkg::word_type descriptor_offset_word_in,
	input wire assoc_decode_pkg::word_type assoc_pointer_word_in,
	input wire logic assoc_fetch_enable_in,
	// Association read port toward system memory
	output logic mem_req_valid_out,
	input wire logic mem_req_ready_in,
	output assoc_decode_pkg::word_type mem_req_addr_out,
	input wire logic mem_rsp_valid_in,
	input wire assoc_decode_pkg::word_type mem_rsp_data_in,
	// Decoded settings toward the engines
	output logic cfg_valid_out,
	input wire logic job_done_in,
	output logic [6:0] auth_algo_out,
	output logic [3:0] cipher_algo_out,
	output logic enc_type_out,
	output logic [1:0] key_size_out,
	output logic parallel_engines_out,
	output logic gcm_mode_out,
	output assoc_decode_pkg::word_type total_message_bytes_out,
	output assoc_decode_pkg::word_type ciphered_byte_count_out,
	output assoc_decode_pkg::word_type cipher_start_offset_out,
	output assoc_decode_pkg::word_type aad_byte_count_out,
	// Key and IV stream toward the engines
	output logic key_valid_out,
	output assoc_decode_pkg::index_type key_index_out,
	output assoc_decode_pkg::word_type key_data_out,
	// Status
	output logic assoc_held_out
);
	import assoc_decode_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	dec_state_type state_r, state_nxt;
	index_type idx_r, idx_nxt;
	word_type len_r, off_r, ptr_r, ctrl_r;
	logic held_r;
	logic key_vld_r;
	index_type key_idx_r;
	logic [6:0] auth_algo_r;
	logic [3:0] cipher_algo_r;
	logic enc_type_r, parallel_r, gcm_r;
	logic [1:0] key_size_r;
	word_type total_r, ciph_cnt_r, start_off_r, aad_r;

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	wire desc_take = (state_r == ST_IDLE) && desc_valid_in;
	wire req_take = (state_r == ST_FETCH_REQ) && mem_req_ready_in;
	wire rsp_take = (state_r == ST_FETCH_WAIT) && mem_rsp_valid_in;
	wire rsp_is_ctrl = rsp_take && (idx_r == `ASSOC_CTRL_INDEX);
	wire rsp_is_key = rsp_take && (idx_r != `ASSOC_CTRL_INDEX);
	wire fetch_last = rsp_take && (idx_r == `ASSOC_LAST_WORD);
	wire emit_rd = (state_r == ST_EMIT);
	wire emit_last = emit_rd && (idx_r == `ASSOC_LAST_KEY_WORD);
	wire [3:0] ctrl_cipher = ctrl_r[`CTRL_CIPHER_ALGO_MSB:`CTRL_CIPHER_ALGO_LSB];
	wire ctrl_gcm = (ctrl_cipher == `CIPHER_ALGO_GCM);
	wire ctrl_parallel = (ctrl_r[`CTRL_MULTITASK_MSB:`CTRL_MULTITASK_LSB] != `MULTITASK_SERIAL);
	wire index_type store_wr_addr = idx_r - `ASSOC_FIRST_KEY_INDEX;
	word_type store_rd_data;

	assign desc_ready_out = (state_r == ST_IDLE);
	assign mem_req_valid_out = (state_r == ST_FETCH_REQ);
	// Association words are consecutive from the pointer, one word per index.
	assign mem_req_addr_out = ptr_r + (word_type'(idx_r) << `ASSOC_WORD_SHIFT);
	assign cfg_valid_out = (state_r == ST_READY);
	assign assoc_held_out = held_r;

	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		unique case (state_r)
			ST_IDLE: begin
				idx_nxt = `ASSOC_CTRL_INDEX;
				if (desc_valid_in) begin
					// A reuse with nothing held yet still fetches, so no engine ever runs on defaults.
					if (assoc_fetch_enable_in || !held_r) begin
						state_nxt = ST_FETCH_REQ;
					end else begin
						state_nxt = ST_EMIT;
					end
				end
			end
			ST_FETCH_REQ: begin
				if (mem_req_ready_in) begin
					state_nxt = ST_FETCH_WAIT;
				end
			end
			ST_FETCH_WAIT: begin
				if (mem_rsp_valid_in) begin
					if (fetch_last) begin
						state_nxt = ST_EMIT;
						idx_nxt = `INDEX_RESET;
					end else begin
						state_nxt = ST_FETCH_REQ;
						idx_nxt = idx_r + 5'h01;
					end
				end
			end
			ST_EMIT: begin
				idx_nxt = idx_r + 5'h01;
				if (emit_last) begin
					state_nxt = ST_READY;
				end
			end
			ST_READY: begin
				if (job_done_in) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
			idx_r <= `INDEX_RESET;
			key_vld_r <= 1'b0;
			key_idx_r <= `INDEX_RESET;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			key_vld_r <= emit_rd;
			key_idx_r <= idx_r;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			len_r <= `WORD_RESET;
			off_r <= `WORD_RESET;
			ptr_r <= `WORD_RESET;
		end else if (desc_take) begin
			len_r <= descriptor_length_word_in;
			off_r <= descriptor_offset_word_in;
			ptr_r <= assoc_pointer_word_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_r <= `WORD_RESET;
			held_r <= 1'b0;
		end else if (rsp_is_ctrl) begin
			ctrl_r <= mem_rsp_data_in;
			held_r <= 1'b0;
		end else if (fetch_last) begin
			held_r <= 1'b1;
		end
	end

	// Settings are latched as the last key word is read, so the engines see a
	// consistent set for the whole of cfg_valid_out.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			auth_algo_r <= 7'h00;
			cipher_algo_r <= 4'h0;
			enc_type_r <= 1'b0;
			key_size_r <= 2'h0;
			parallel_r <= 1'b0;
			gcm_r <= 1'b0;
			total_r <= `WORD_RESET;
			ciph_cnt_r <= `WORD_RESET;
			start_off_r <= `WORD_RESET;
			aad_r <= `WORD_RESET;
		end else if (emit_last) begin
			auth_algo_r <= ctrl_r[`CTRL_AUTH_ALGO_MSB:`CTRL_AUTH_ALGO_LSB];
			cipher_algo_r <= ctrl_cipher;
			enc_type_r <= ctrl_r[`CTRL_ENC_TYPE_BIT];
			key_size_r <= ctrl_r[`CTRL_KEY_SIZE_MSB:`CTRL_KEY_SIZE_LSB];
			parallel_r <= ctrl_parallel;
			gcm_r <= ctrl_gcm;
			total_r <= ctrl_gcm ? `WORD_RESET : len_r;
			ciph_cnt_r <= ctrl_gcm ? len_r : `WORD_RESET;
			start_off_r <= ctrl_gcm ? `WORD_RESET : off_r;
			aad_r <= ctrl_gcm ? off_r : `WORD_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Key store

	assoc_store u_store (
		.ref_clk_in(ref_clk_in),
		.wr_en_in(rsp_is_key),
		.wr_addr_in(store_wr_addr),
		.wr_data_in(mem_rsp_data_in),
		.rd_en_in(emit_rd),
		.rd_addr_in(idx_r),
		.rd_data_out(store_rd_data)
	);

	assign auth_algo_out = auth_algo_r;
	assign cipher_algo_out = cipher_algo_r;
	assign enc_type_out = enc_type_r;
	assign key_size_out = key_size_r;
	assign parallel_engines_out = parallel_r;
	assign gcm_mode_out = gcm_r;
	assign total_message_bytes_out = total_r;
	assign ciphered_byte_count_out = ciph_cnt_r;
	assign cipher_start_offset_out = start_off_r;
	assign aad_byte_count_out = aad_r;
	assign key_valid_out = key_vld_r;
	assign key_index_out = key_idx_r;
	// The store's read register is reset-free; its value only counts while key_valid_out is high.
	assign key_data_out = store_rd_data;
endmodule

`default_nettype wire

// ### verilog/crypto_descriptor_assoc_decode_regs.svh
/*
 * Constants of the descriptor and security-association decoder: word counts,
 * control-word field positions and reset values.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef CRYPTO_DESCRIPTOR_ASSOC_DECODE_REGS_SVH
`define CRYPTO_DESCRIPTOR_ASSOC_DECODE_REGS_SVH

// Association layout in words: control word, 8 auth key, 8 cipher key, 4 auth IV, 4 cipher IV.
`define ASSOC_LAST_WORD 5'd24
`define ASSOC_LAST_KEY_WORD 5'd23
`define ASSOC_CTRL_INDEX 5'd0
`define ASSOC_FIRST_KEY_INDEX 5'd1
`define ASSOC_STORE_DEPTH 24
`define ASSOC_WORD_SHIFT 2

// Control word field positions.
`define CTRL_AUTH_ALGO_MSB 16
`define CTRL_AUTH_ALGO_LSB 10
`define CTRL_ENC_TYPE_BIT 9
`define CTRL_KEY_SIZE_MSB 8
`define CTRL_KEY_SIZE_LSB 7
`define CTRL_MULTITASK_MSB 6
`define CTRL_MULTITASK_LSB 4
`define CTRL_CIPHER_ALGO_MSB 3
`define CTRL_CIPHER_ALGO_LSB 0

// Cipher algorithm code that selects GCM.
`define CIPHER_ALGO_GCM 4'hE
`define MULTITASK_SERIAL 3'h0

`define WORD_RESET 32'h0000_0000
`define INDEX_RESET 5'h00

`endif

// ### verilog/assoc_decode_pkg.sv
/*
 * Types shared by the association decoder and its key store.
 * Assumes the constants header sits in the include path.
 */
`default_nettype none
`include "crypto_descriptor_assoc_decode_regs.svh"

package assoc_decode_pkg;
	typedef logic [31:0] word_type;
	typedef logic [4:0] index_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH_REQ = 3'b001,
		ST_FETCH_WAIT = 3'b010,
		ST_EMIT = 3'b011,
		ST_READY = 3'b100
	} dec_state_type;
endpackage

`default_nettype wire

// ### verilog/assoc_store.sv
/*
 * Key and IV store of the held security association: one write port, one read
 * port whose data come out of a register one cycle after the read strobe.
 * Assumes a single clock and that writes and reads never target one word at once.
 */
`default_nettype none
`include "crypto_descriptor_assoc_decode_regs.svh"

module assoc_store (
	// Clock
	input wire logic ref_clk_in,
	// Write port
	input wire logic wr_en_in,
	input wire assoc_decode_pkg::index_type wr_addr_in,
	input wire assoc_decode_pkg::word_type wr_data_in,
	// Read port
	input wire logic rd_en_in,
	input wire assoc_decode_pkg::index_type rd_addr_in,
	output assoc_decode_pkg::word_type rd_data_out
);
	import assoc_decode_pkg::*;

	// No reset on the array keeps it mappable to RAM; words are always written before use.
	word_type mem_r [`ASSOC_STORE_DEPTH];
	word_type rd_data_r;

	always_ff @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
		if (rd_en_in) begin
			rd_data_r <= mem_r[rd_addr_in];
		end
	end

	assign rd_data_out = rd_data_r;
endmodule

`default_nettype wire

// ### dv/assoc_mem_model.sv
/* Behavioural memory that answers each read with the inverse of its byte address.
 * Assumes one outstanding read at a time, as the decoder keeps. */
`default_nettype none
module assoc_mem_model (
	// Clock, reset and pacing
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic slow_in,
	// Read port
	input wire logic req_valid_in,
	input wire logic [31:0] req_addr_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [31:0] rsp_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pend_r, stall_r;
	logic [2:0] wait_r;
	logic [31:0] addr_r;
	////////////////////////////////
	// Slow mode refuses offers on every other cycle and answers late, so held requests get exercised.
	assign req_ready_out = req_valid_in & ~pend_r & ~(slow_in & stall_r);
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_r <= 1'b0;
			stall_r <= 1'b0;
			wait_r <= 3'h0;
			rsp_valid_out <= 1'b0;
		end else begin
			stall_r <= ~stall_r;
			rsp_valid_out <= 1'b0;
			// The data lines never keep the last word once the answer is gone.
			rsp_data_out <= ~rsp_data_out;
			if (req_ready_out) begin
				pend_r <= 1'b1;
				addr_r <= req_addr_in;
				wait_r <= slow_in ? 3'h5 : 3'h0;
			end else if (pend_r && wait_r != 3'h0) begin
				wait_r <= wait_r - 3'h1;
			end else if (pend_r) begin
				pend_r <= 1'b0;
				rsp_valid_out <= 1'b1;
				rsp_data_out <= ~addr_r;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/crypto_descriptor_assoc_decode_props.sv
/* Port assertions of the association decoder.
 * Assumes it is bound to every decoder instance. */
`default_nettype none
`include "crypto_descriptor_assoc_decode_regs.svh"
module crypto_descriptor_assoc_decode_props (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Descriptor and memory
	input wire logic desc_valid_in,
	input wire logic desc_ready_out,
	input wire assoc_decode_pkg::word_type assoc_pointer_word_in,
	input wire logic assoc_fetch_enable_in,
	input wire logic mem_req_valid_out,
	input wire logic mem_req_ready_in,
	input wire assoc_decode_pkg::word_type mem_req_addr_out,
	// Engine side
	input wire logic cfg_valid_out,
	input wire logic job_done_in,
	input wire logic [3:0] cipher_algo_out,
	input wire logic gcm_mode_out,
	input wire assoc_decode_pkg::word_type total_message_bytes_out,
	input wire assoc_decode_pkg::word_type ciphered_byte_count_out,
	input wire logic key_valid_out,
	input wire assoc_decode_pkg::index_type key_index_out,
	input wire logic assoc_held_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import assoc_decode_pkg::*;
	wire logic take = desc_valid_in & desc_ready_out;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////
	a_fetch_base: assert property (
		take && (assoc_fetch_enable_in || !assoc_held_out) |=>
		mem_req_valid_out && mem_req_addr_out == $past(assoc_pointer_word_in)) else $error("fetch not at pointer");
	a_reuse_quiet: assert property (
		take && !assoc_fetch_enable_in && assoc_held_out |=>
		(!mem_req_valid_out throughout (1'b1 ##[0:2] (key_valid_out && key_index_out == 5'd0))))
		else $error("reuse fetched");
	a_req_hold: assert property (
		mem_req_valid_out && !mem_req_ready_in |=> mem_req_valid_out && $stable(mem_req_addr_out))
		else $error("request dropped");
	a_busy_ready: assert property (take |=> !desc_ready_out) else $error("ready while busy");
	a_done_idle: assert property (
		cfg_valid_out && job_done_in |=> desc_ready_out && !cfg_valid_out) else $error("done ignored");
	a_cfg_last: assert property (
		$rose(cfg_valid_out) |-> key_valid_out && key_index_out == 5'd23) else $error("cfg not at last key");
	a_key_run: assert property (
		$rose(key_valid_out) |-> (key_index_out == 5'd0) ##0 key_valid_out [*8]) else $error("key run broken");
	a_gcm_route: assert property (
		cfg_valid_out |-> gcm_mode_out == (cipher_algo_out == `CIPHER_ALGO_GCM) &&
		(gcm_mode_out ? total_message_bytes_out == 32'h0 : ciphered_byte_count_out == 32'h0))
		else $error("length routing");
	c_reuse: cover property (take && !assoc_fetch_enable_in && assoc_held_out);
	c_gcm: cover property (cfg_valid_out && gcm_mode_out);
	c_stall: cover property (mem_req_valid_out && !mem_req_ready_in);
endmodule
bind crypto_descriptor_assoc_decode crypto_descriptor_assoc_decode_props props_i (.*);
`default_nettype wire

// ### dv/tb_top.sv
/* Self-checking bench: decoder, memory model and bound checker.
 * Assumes package, design, model and checker compile first. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import assoc_decode_pkg::*;
	logic clk = 1'b0, rn = 1'b0, dv = 1'b0, fe = 1'b0, dn = 1'b0, slow = 1'b0;
	logic rdy, mv, mr, rv, cv, et, pe, gm, kv, hd;
	logic [6:0] aa;
	logic [3:0] ca;
	logic [1:0] ks;
	word_type lw = 32'h0, ow = 32'h0, pw = 32'h0, p, r = 32'hCD13;
	word_type ma, rd, tm, cb, so, ab, kd;
	index_type ki;
	int err_count = 0, check_count = 0;
	always #4 clk = ~clk;
	crypto_descriptor_assoc_decode uut (.ref_clk_in(clk), .rst_n_in(rn), .desc_valid_in(dv), .desc_ready_out(rdy),
		.descriptor_length_word_in(lw), .descriptor_offset_word_in(ow), .assoc_pointer_word_in(pw),
		.assoc_fetch_enable_in(fe), .mem_req_valid_out(mv), .mem_req_ready_in(mr), .mem_req_addr_out(ma),
		.mem_rsp_valid_in(rv), .mem_rsp_data_in(rd), .cfg_valid_out(cv), .job_done_in(dn), .auth_algo_out(aa),
		.cipher_algo_out(ca), .enc_type_out(et), .key_size_out(ks), .parallel_engines_out(pe), .gcm_mode_out(gm),
		.total_message_bytes_out(tm), .ciphered_byte_count_out(cb), .cipher_start_offset_out(so),
		.aad_byte_count_out(ab), .key_valid_out(kv), .key_index_out(ki), .key_data_out(kd), .assoc_held_out(hd));
	assoc_mem_model mem (.ref_clk_in(clk), .rst_n_in(rn), .slow_in(slow), .req_valid_in(mv), .req_addr_in(ma),
		.req_ready_out(mr), .rsp_valid_out(rv), .rsp_data_out(rd));
	////////////////////////////////
	function automatic word_type lfsr(input word_type s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// The model answers each word with the inverse of its byte address.
	function automatic word_type key_exp(input word_type k, input int i);
		return ~(k + 32'(4 * (i + 1)));
	endfunction
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// The pointer p is offered; k is the association that the keys must come from.
	task automatic job(input word_type p, k, l, o, input logic f);
		word_type c;
		int i;
		int n;
		c = ~k;
		i = 0;
		dv <= 1'b1;
		lw <= l;
		ow <= o;
		pw <= p;
		fe <= f;
		for (n = 0; n < 9 && rdy !== 1'b1; n++) @(negedge clk);
		if (rdy !== 1'b1) begin
			chk(1'b0, "descriptor not taken");
			results();
		end
		@(negedge clk);
		dv <= 1'b0;
		for (n = 0; n < 600 && cv !== 1'b1; n++) begin
			@(negedge clk);
			if (kv === 1'b1) begin
				chk(ki === i[4:0] && kd === key_exp(k, i), "key word");
				i++;
			end
		end
		if (cv !== 1'b1) begin
			chk(1'b0, "timeout");
			results();
		end
		chk(i == 24 && hd === 1'b1, "key count");
		chk({aa, ca, et, ks, pe, gm} === {c[16:10], c[3:0], c[9], c[8:7], |c[6:4], c[3:0] == 4'hE}, "fields");
		chk({tm, cb, so, ab} === (c[3:0] == 4'hE ? {32'h0, l, 32'h0, o} : {l, 32'h0, o, 32'h0}), "lengths");
		dn <= 1'b1;
		@(negedge clk);
		dn <= 1'b0;
		chk(rdy === 1'b1 && cv === 1'b0, "done");
		$display("job end %0t", $time);
	endtask
	////////////////////////////////
	initial begin
		repeat (6) @(negedge clk);
		rn <= 1'b1;
		chk(rdy === 1'b1 && cv === 1'b0 && kv === 1'b0 && hd === 1'b0 && mv === 1'b0, "reset values");
		for (int a = 0; a < 16; a++) begin
			r = lfsr(r);
			slow <= r[0];
			p = ~{r[31:4], a[3:0]};
			job(p, p, r, {r[15:0], r[31:16]}, 1'b1);
		end
		// A new pointer without the fetch flag must leave the held association in use.
		job(32'h0000_1000, p, 32'h0, 32'hFFFF_FFFF, 1'b0);
		rn <= 1'b0;
		@(negedge clk);
		// A reset in mid-run must drop the held association, so the next reuse has to fetch.
		chk(hd === 1'b0 && rdy === 1'b1 && cv === 1'b0 && kv === 1'b0 && mv === 1'b0, "mid reset values");
		rn <= 1'b1;
		p = ~32'h0000_000E;
		job(p, p, 32'hFFFF_FFFF, 32'h0, 1'b0);
		results();
	end
endmodule
`default_nettype wire
